// [src/flash_seq_pkg.sv]
// Summary of operation
// - reject program/erase until divider gives valid clock
// - clock divider accepts one write after reset
// - pulses timed in whole timing-clock periods
// - byte program, page/mass erase, blank check
// - buffer-empty flag set while buffer can accept
// - complete flag only when all done, none waiting
// - protected target sets violation, array untouched
// - other sequence departures set access error
// - sequence starts with array write, latched
// - erase/blank ignore data, any address in range
// - command code written second, five valid codes
// - writing one to empty flag registers command
// - writing zero mid-sequence aborts with access error
// - byte, row, page address fields
// - smallest erase is one whole page
// - lowest 128 array bytes hidden behind RAM
// - burst shortcut needs same row, registered early
// - full program phase order and lengths
// - command start synchronised to timing clock edge
// - chained burst skips all but byte programming
// - durations 9, 4, 4000, 40000 timing cycles
// - access error sticky, blocks new commands
// - invalid command code sets access error
// - array write while buffer full is error
// - stop mode aborts operation, sets access error
package flash_seq_pkg;
  localparam int BUS_HZ      = 20_000_000;
  localparam int NV_TIMING_CLOCK_MIN_HZ = 150_000;
  localparam int NV_TIMING_CLOCK_MAX_HZ = 200_000;
  // divider period bounds in bus cycles; shortest period is fastest clock
  localparam logic [9:0] PERIOD_MIN = 10'(BUS_HZ / NV_TIMING_CLOCK_MAX_HZ);
  localparam logic [9:0] PERIOD_MAX = 10'(BUS_HZ / NV_TIMING_CLOCK_MIN_HZ);

  localparam logic [11:0] OFF_DIV  = 12'h000;
  localparam logic [11:0] OFF_PROT = 12'h004;
  localparam logic [11:0] OFF_STAT = 12'h008;
  localparam logic [11:0] OFF_CMD  = 12'h00c;
  localparam logic [11:0] OFF_ARR  = 12'h010;

  localparam int DIV_LOADED = 7;
  localparam int DIV_PRE8   = 6;
  localparam int ST_CBEF    = 7;
  localparam int ST_CCF     = 6;
  localparam int ST_PVIOL   = 5;
  localparam int ST_ACCERR  = 4;
  localparam int ST_BLANK   = 2;
  localparam int PROT_OPEN  = 7;
  localparam int PROT_DIS   = 6;
  localparam int ARR_DATA_LSB = 16;

  localparam logic [7:0] CMD_BLANK = 8'h05;
  localparam logic [7:0] CMD_BYTE  = 8'h20;
  localparam logic [7:0] CMD_BURST = 8'h25;
  localparam logic [7:0] CMD_PAGE  = 8'h40;
  localparam logic [7:0] CMD_MASS  = 8'h41;

  localparam logic [15:0] ARRAY_BASE   = 16'h1000;
  localparam logic [15:0] ARRAY_TOP    = 16'hffff;
  localparam logic [15:0] HIDDEN_BYTES = 16'h0080;
  localparam int ROW_LSB  = 6;
  localparam int PAGE_LSB = 9;
  localparam logic [15:0] PAGE_BYTES = 16'h0200;

  localparam logic [15:0] T_NV_SETUP = 16'h0001;
  localparam logic [15:0] T_PG_SETUP = 16'h0002;
  localparam logic [15:0] T_PROG     = 16'h0004;
  localparam logic [15:0] T_NV_HOLD  = 16'h0001;
  localparam logic [15:0] T_RECOVER  = 16'h0001;
  localparam int PAGE_ERASE_TICKS = 4000;
  localparam int MASS_ERASE_TICKS = 40000;

  typedef enum {SEQ_IDLE, SEQ_ADDR, SEQ_CMD} seq_e;
  typedef enum {X_IDLE, X_START, X_NV_SETUP, X_PG_SETUP, X_PROG,
                X_NV_HOLD, X_RECOVER, X_ERASE, X_BLANK} exec_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic        hv_on;
    logic        prog;
    logic        erase;
    logic        erase_all;
  } nv_ctrl_s;

  typedef struct packed {
    logic [7:0]  cmd;
    logic [15:0] addr;
    logic [7:0]  data;
  } cmd_buf_s;
endpackage

// [src/flash_command_sequencer.sv]
`timescale 1ns/10ps
`default_nettype none
module flash_command_sequencer #(
  parameter int PAGE_ERASE = flash_seq_pkg::PAGE_ERASE_TICKS,
  parameter int MASS_ERASE = flash_seq_pkg::MASS_ERASE_TICKS
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [11:0]            s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output var  logic                   s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output var  logic                   s_axi_wready,
  output var  logic [1:0]             s_axi_bresp,
  output var  logic                   s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [11:0]            s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output var  logic                   s_axi_arready,
  output var  logic [31:0]            s_axi_rdata,
  output var  logic [1:0]             s_axi_rresp,
  output var  logic                   s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic [7:0]             nv_protect_setting,
  input  wire logic                   stop_mode_req,
  output var  flash_seq_pkg::nv_ctrl_s nv_ctrl,
  input  wire logic [7:0]             nv_rd_data
);
  import flash_seq_pkg::*;

  function automatic logic [9:0] div_period(input logic [7:0] d);
    logic [9:0] base;
    base = {4'h0, d[5:0]} + 10'h001;
    div_period = d[DIV_PRE8] ? {base[6:0], 3'h0} : base;
  endfunction

  function automatic logic is_protected(input logic [15:0] a,
                                        input logic [7:0] p);
    logic [15:0] size;
    size = PAGE_BYTES << ((p[2:0] > 3'h6) ? 3'h6 : p[2:0]);
    is_protected = !p[PROT_OPEN] ||
                   (!p[PROT_DIS] && (a >= (ARRAY_TOP - size + 16'h0001)));
  endfunction

  // ---------------- bus slave ----------------
  logic        aw_have_q, w_have_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_fire, wr_mapped, wr_div, wr_stat, wr_cmd, wr_arr;

  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= 12'h000;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // one write in flight: ready drops once an item is held
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready) &&
                       !wr_fire && !s_axi_bvalid;
      s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready) &&
                       !wr_fire && !s_axi_bvalid;
    end
  end

  always_comb begin
    wr_mapped = (awaddr_q == OFF_DIV) || (awaddr_q == OFF_PROT) ||
                (awaddr_q == OFF_STAT) || (awaddr_q == OFF_CMD) ||
                (awaddr_q == OFF_ARR);
    wr_div  = wr_fire && wstrb_q[0] && (awaddr_q == OFF_DIV);
    wr_stat = wr_fire && wstrb_q[0] && (awaddr_q == OFF_STAT);
    wr_cmd  = wr_fire && wstrb_q[0] && (awaddr_q == OFF_CMD);
    wr_arr  = wr_fire && (wstrb_q[2:0] == 3'h7) && (awaddr_q == OFF_ARR);
  end

  // ---------------- divider and timing clock ----------------
  logic [7:0] div_q;
  logic [9:0] tick_cnt_q;
  logic       tick;
  logic       div_ok;
  seq_e       seq_q, seq_d;

  assign div_ok = div_q[DIV_LOADED] && (div_period(div_q) >= PERIOD_MIN) &&
                  (div_period(div_q) <= PERIOD_MAX);
  assign tick   = div_q[DIV_LOADED] && (tick_cnt_q == 10'h000);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 8'h00;
    end else if (wr_div && !div_q[DIV_LOADED] && seq_q == SEQ_IDLE) begin
      div_q <= {1'b1, wdata_q[6:0]};
    end
  end

  // free-running period counter gives the timing-clock edges
  always_ff @(posedge aclk) begin
    if (!aresetn || !div_q[DIV_LOADED]) begin
      tick_cnt_q <= 10'h000;
    end else if (tick) begin
      tick_cnt_q <= div_period(div_q) - 10'h001;
    end else begin
      tick_cnt_q <= tick_cnt_q - 10'h001;
    end
  end

  // ---------------- stop mode synchroniser ----------------
  logic stop_meta_q, stop_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_meta_q <= 1'b0;
      stop_q      <= 1'b0;
    end else begin
      stop_meta_q <= stop_mode_req;
      stop_q      <= stop_meta_q;
    end
  end

  // ---------------- command sequence checker ----------------
  cmd_buf_s latch_q, latch_d;
  cmd_buf_s pend_q;
  logic     pend_q_v;
  logic     seq_err, do_register, pviol_set;
  logic     accerr_q, pviol_q, blank_q;
  logic     exec_busy, take_pend, burst_chain, stop_abort;
  logic [15:0] arr_addr;
  logic        code_ok, code_hv;

  assign arr_addr = wdata_q[15:0];

  always_comb begin
    code_ok = (wdata_q[7:0] == CMD_BLANK) || (wdata_q[7:0] == CMD_BYTE) ||
              (wdata_q[7:0] == CMD_BURST) || (wdata_q[7:0] == CMD_PAGE) ||
              (wdata_q[7:0] == CMD_MASS);
    code_hv = code_ok && (wdata_q[7:0] != CMD_BLANK);
    seq_d       = seq_q;
    latch_d     = latch_q;
    seq_err     = 1'b0;
    do_register = 1'b0;
    pviol_set   = 1'b0;
    if (wr_arr) begin
      // buffer full / error pending / hidden bytes
      if (!div_q[DIV_LOADED] || pend_q_v || accerr_q ||
          seq_q != SEQ_IDLE || arr_addr < ARRAY_BASE + HIDDEN_BYTES) begin
        seq_err = 1'b1;
      end else begin
        seq_d        = SEQ_ADDR;
        latch_d.addr = arr_addr;
        latch_d.data = wdata_q[ARR_DATA_LSB +: 8];
      end
    end else if (wr_cmd) begin
      if (seq_q != SEQ_ADDR || !code_ok || (code_hv && !div_ok)) begin
        seq_err = 1'b1;
      end else begin
        seq_d       = SEQ_CMD;
        latch_d.cmd = wdata_q[7:0];
      end
    end else if (wr_stat && seq_q != SEQ_IDLE) begin
      seq_d = SEQ_IDLE;
      if (seq_q == SEQ_CMD && wdata_q[ST_CBEF]) begin
        if (latch_q.cmd == CMD_MASS) begin
          pviol_set = is_protected(ARRAY_TOP, nv_protect_setting);
        end else if (latch_q.cmd != CMD_BLANK) begin
          pviol_set = is_protected(latch_q.addr, nv_protect_setting);
        end
        do_register = !pviol_set;
      end else begin
        // abort by writing zero, other order faults
        seq_err = 1'b1;
      end
    end else if (wr_div && seq_q != SEQ_IDLE) begin
      seq_err = 1'b1;
    end
    if (seq_err) begin
      seq_d = SEQ_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_q   <= SEQ_IDLE;
      latch_q <= '0;
    end else begin
      seq_q   <= seq_d;
      latch_q <= latch_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_q_v <= 1'b0;
      pend_q   <= '0;
    end else if (do_register) begin
      pend_q_v <= 1'b1;
      pend_q   <= latch_q;
    end else if (take_pend || burst_chain || stop_abort) begin
      pend_q_v <= 1'b0;
    end
  end

  // ---------------- operation engine ----------------
  exec_e       x_q;
  cmd_buf_s    act_q;
  logic [15:0] tcnt_q;
  logic [15:0] scan_q;
  logic        scan_chk_q, scan_done_q;
  logic        phase_end;

  assign exec_busy  = (x_q != X_IDLE);
  assign take_pend  = !exec_busy && pend_q_v;
  assign phase_end  = tick && (tcnt_q == 16'h0001);
  assign stop_abort = stop_q && (exec_busy || pend_q_v);
  assign burst_chain = (x_q == X_PROG) && phase_end &&
                       (act_q.cmd == CMD_BURST) && pend_q_v &&
                       (pend_q.cmd == CMD_BURST) &&
                       (pend_q.addr[15:ROW_LSB] == act_q.addr[15:ROW_LSB]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      x_q         <= X_IDLE;
      act_q       <= '0;
      tcnt_q      <= 16'h0000;
      scan_q      <= ARRAY_BASE;
      scan_chk_q  <= 1'b0;
      scan_done_q <= 1'b0;
    end else if (stop_abort) begin
      x_q <= X_IDLE;
    end else begin
      case (x_q)
        X_IDLE: begin
          if (take_pend) begin
            act_q <= pend_q;
            x_q   <= X_START;
          end
        end
        // wait for the next timing-clock edge
        X_START: begin
          if (tick) begin
            case (act_q.cmd)
              CMD_PAGE: begin
                x_q    <= X_ERASE;
                tcnt_q <= 16'(PAGE_ERASE);
                act_q.addr <= {act_q.addr[15:PAGE_LSB], 9'h000};
              end
              CMD_MASS: begin
                x_q    <= X_ERASE;
                tcnt_q <= 16'(MASS_ERASE);
              end
              CMD_BLANK: begin
                x_q         <= X_BLANK;
                scan_q      <= ARRAY_BASE;
                scan_chk_q  <= 1'b0;
                scan_done_q <= 1'b0;
              end
              default: begin
                x_q    <= X_NV_SETUP;
                tcnt_q <= T_NV_SETUP;
              end
            endcase
          end
        end
        X_NV_SETUP: begin
          if (phase_end) begin
            x_q    <= X_PG_SETUP;
            tcnt_q <= T_PG_SETUP;
          end else if (tick) begin
            tcnt_q <= tcnt_q - 16'h0001;
          end
        end
        X_PG_SETUP: begin
          if (phase_end) begin
            x_q    <= X_PROG;
            tcnt_q <= T_PROG;
          end else if (tick) begin
            tcnt_q <= tcnt_q - 16'h0001;
          end
        end
        X_PROG: begin
          if (burst_chain) begin
            act_q  <= pend_q;
            tcnt_q <= T_PROG;
          end else if (phase_end) begin
            x_q    <= X_NV_HOLD;
            tcnt_q <= T_NV_HOLD;
          end else if (tick) begin
            tcnt_q <= tcnt_q - 16'h0001;
          end
        end
        X_NV_HOLD: begin
          if (phase_end) begin
            x_q    <= X_RECOVER;
            tcnt_q <= T_RECOVER;
          end else if (tick) begin
            tcnt_q <= tcnt_q - 16'h0001;
          end
        end
        X_RECOVER, X_ERASE: begin
          if (phase_end) begin
            x_q <= X_IDLE;
          end else if (tick) begin
            tcnt_q <= tcnt_q - 16'h0001;
          end
        end
        // one array byte compared per bus cycle
        X_BLANK: begin
          scan_chk_q <= !scan_done_q;
          if (scan_q == ARRAY_TOP) begin
            scan_done_q <= 1'b1;
          end else begin
            scan_q <= scan_q + 16'h0001;
          end
          if (scan_done_q && !scan_chk_q) begin
            x_q <= X_IDLE;
          end
        end
        default: x_q <= X_IDLE;
      endcase
    end
  end

  // ---------------- status flags, set wins over clear ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      accerr_q <= 1'b0;
      pviol_q  <= 1'b0;
      blank_q  <= 1'b0;
    end else begin
      // sticky until a one is written
      if (seq_err || stop_abort) begin
        accerr_q <= 1'b1;
      end else if (wr_stat && wdata_q[ST_ACCERR]) begin
        accerr_q <= 1'b0;
      end
      if (pviol_set) begin
        pviol_q <= 1'b1;
      end else if (wr_stat && wdata_q[ST_PVIOL]) begin
        pviol_q <= 1'b0;
      end
      if (x_q == X_START && tick && act_q.cmd == CMD_BLANK) begin
        blank_q <= 1'b1;
      end else if (x_q == X_BLANK && scan_chk_q && nv_rd_data != 8'hff) begin
        blank_q <= 1'b0;
      end
    end
  end

  // ---------------- array-side controls ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nv_ctrl <= '0;
    end else begin
      nv_ctrl.addr <= (x_q == X_BLANK) ? scan_q : act_q.addr;
      nv_ctrl.data <= act_q.data;
      nv_ctrl.hv_on <= (x_q inside {X_NV_SETUP, X_PG_SETUP, X_PROG,
                                    X_NV_HOLD, X_ERASE}) && !stop_abort;
      nv_ctrl.prog  <= (x_q == X_PROG) && !stop_abort;
      nv_ctrl.erase <= (x_q == X_ERASE) && !stop_abort;
      nv_ctrl.erase_all <= (x_q == X_ERASE) && (act_q.cmd == CMD_MASS) &&
                           !stop_abort;
    end
  end

  // ---------------- register reads ----------------
  logic [7:0] stat_rd;
  // empty and complete flags from buffer and engine
  assign stat_rd = {!pend_q_v, !pend_q_v && !exec_busy, pviol_q, accerr_q,
                    1'b0, blank_q, 2'h0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case (s_axi_araddr)
          OFF_DIV:  s_axi_rdata <= {24'h000000, div_q};
          OFF_PROT: s_axi_rdata <= {24'h000000, nv_protect_setting};
          OFF_STAT: s_axi_rdata <= {24'h000000, stat_rd};
          OFF_CMD:  s_axi_rdata <= {24'h000000, latch_q.cmd};
          OFF_ARR:  s_axi_rdata <= {8'h00, latch_q.data, latch_q.addr};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [verification/flash_array_model.sv]
`timescale 1ns/10ps
`default_nettype none
module flash_array_model
  import flash_seq_pkg::*;
(
  input  wire logic     aclk,
  input  wire nv_ctrl_s nv_ctrl,
  output logic [7:0]    rd_data
);
  logic [7:0] mem [0:65535];
  logic       erase_q = 1'b0;
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
  end
  assign rd_data = mem[nv_ctrl.addr];
  always @(posedge aclk) begin
    erase_q <= nv_ctrl.erase;
    if (nv_ctrl.hv_on && nv_ctrl.prog) begin
      mem[nv_ctrl.addr] <= mem[nv_ctrl.addr] & nv_ctrl.data;
    end
    if (nv_ctrl.erase && !erase_q) begin
      for (int i = 0; i < 65536; i++) begin
        if (nv_ctrl.erase_all || (i >> 9) == int'(nv_ctrl.addr[15:9])) begin
          mem[i] <= 8'hff;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [verification/flash_command_sequencer_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module flash_command_sequencer_assertions
  import flash_seq_pkg::*;
#(
  parameter int PAGE_ERASE = 8,
  parameter int MASS_ERASE = 16
) (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [7:0] nv_protect_setting,
  input wire logic       stop_mode_req,
  input wire nv_ctrl_s   nv_ctrl
);
  logic [19:0] pcnt_q;
  logic [19:0] ecnt_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    pcnt_q <= (aresetn && nv_ctrl.prog) ? pcnt_q + 20'h1 : 20'h0;
  end
  always_ff @(posedge aclk) begin
    ecnt_q <= (aresetn && nv_ctrl.erase) ? ecnt_q + 20'h1 : 20'h0;
  end
  property p_b_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_prot_all;
    !nv_protect_setting[PROT_OPEN]
      |-> !$rose(nv_ctrl.prog) && !$rose(nv_ctrl.erase);
  endproperty
  a_prot_all: assert property (p_prot_all)
    else $error("protected array changed");
  property p_prog_hv;
    nv_ctrl.prog |-> nv_ctrl.hv_on;
  endproperty
  a_prog_hv: assert property (p_prog_hv)
    else $error("program without high voltage");
  property p_prog_setup;
    $rose(nv_ctrl.prog) |-> $past(nv_ctrl.hv_on, 8);
  endproperty
  a_prog_setup: assert property (p_prog_setup)
    else $error("program setup skipped");
  property p_prog_len;
    $fell(nv_ctrl.prog) |-> pcnt_q >= 20'(4 * PERIOD_MIN);
  endproperty
  a_prog_len: assert property (p_prog_len)
    else $error("program pulse short");
  property p_erase_page;
    nv_ctrl.erase && !nv_ctrl.erase_all |-> nv_ctrl.addr[8:0] == 9'h000;
  endproperty
  a_erase_page: assert property (p_erase_page)
    else $error("erase not page aligned");
  property p_erase_len;
    $fell(nv_ctrl.erase) && !stop_mode_req
      |-> ecnt_q >= 20'(PAGE_ERASE * PERIOD_MIN);
  endproperty
  a_erase_len: assert property (p_erase_len)
    else $error("erase pulse short");
  property p_stop;
    stop_mode_req [*4] |-> ##2 !nv_ctrl.hv_on;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop did not abort");
  property p_row;
    nv_ctrl.prog && $past(nv_ctrl.prog) |-> $stable(nv_ctrl.addr[15:6]);
  endproperty
  a_row: assert property (p_row)
    else $error("burst left its row");
  c_burst: cover property ($fell(nv_ctrl.prog) && pcnt_q > 20'(4 * PERIOD_MAX));
  c_mass: cover property ($fell(nv_ctrl.erase_all)
    && ecnt_q >= 20'(MASS_ERASE * PERIOD_MIN));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule
bind flash_command_sequencer flash_command_sequencer_assertions #(
  .PAGE_ERASE(PAGE_ERASE),
  .MASS_ERASE(MASS_ERASE)
) u_flash_command_sequencer_assertions (.*);
`default_nettype wire

// [verification/flash_command_sequencer_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module flash_command_sequencer_tb;
  import flash_seq_pkg::*;
  localparam int PER = 104;
  localparam int PE  = 8;
  localparam int ME  = 16;
  logic        aclk = 1'b0;
  logic        aresetn, stop_mode_req, s_axi_bready, s_axi_rready;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  nv_protect_setting, nv_rd_data;
  nv_ctrl_s    nv_ctrl;
  int          fails, compares, prun, plen, erun, elen;
  flash_command_sequencer #(.PAGE_ERASE(PE), .MASS_ERASE(ME))
    u_flash_command_sequencer (.*);
  flash_array_model u_flash_array_model (
    .aclk   (aclk),
    .nv_ctrl(nv_ctrl),
    .rd_data(nv_rd_data)
  );
  always #25 aclk = ~aclk;
  // pulse lengths of the last program and erase, in bus cycles
  always @(posedge aclk) begin
    prun <= nv_ctrl.prog ? prun + 1 : 0;
    erun <= nv_ctrl.erase ? erun + 1 : 0;
    if (!nv_ctrl.prog && prun != 0) plen <= prun;
    if (!nv_ctrl.erase && erun != 0) elen <= erun;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    bit ad = 1'b0;
    bit wd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (s_axi_awready && !ad) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !wd) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(r));
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk(32'(s_axi_rresp), 32'(r));
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d, 2'b00);
    chk(d, exp);
  endtask
  // reads the status, then clears both sticky error flags
  task automatic errchk(input logic [31:0] exp);
    rchk(OFF_STAT, exp);
    wr(OFF_STAT, 32'h30, 2'b00);
  endtask
  task automatic seq(input logic [15:0] a, input logic [7:0] d,
                     input logic [7:0] c);
    wr(OFF_ARR, {8'h00, d, a}, 2'b00);
    wr(OFF_CMD, {24'h0, c}, 2'b00);
    wr(OFF_STAT, 32'h80, 2'b00);
  endtask
  task automatic wait_done;
    int n = 0;
    do begin
      rd(OFF_STAT, rv, 2'b00);
      n++;
    end while (rv[ST_CCF] !== 1'b1 && n < 25000);
    chk(32'(rv[ST_CCF]), 32'h1);
  endtask
  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask
  task automatic report_and_stop;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #(90000 * 50);
    fails++;
    report_and_stop;
  end
  initial begin
    {aresetn, stop_mode_req, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_arvalid, s_axi_bready, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    nv_protect_setting = 8'hc0;
    do_reset;
    wr(OFF_ARR, 32'h005a2000, 2'b00);
    errchk(32'hd0);
    rchk(OFF_STAT, 32'hc0);
    wr(OFF_DIV, 32'h05, 2'b00);
    wr(OFF_ARR, 32'h005a2000, 2'b00);
    wr(OFF_CMD, {24'h0, CMD_BYTE}, 2'b00);
    rchk(OFF_STAT, 32'hd0);
    do_reset;
    wr(OFF_DIV, 32'h4c, 2'b00);
    wr(OFF_DIV, 32'h00, 2'b00);
    rchk(OFF_DIV, 32'hcc);
    rchk(OFF_PROT, 32'hc0);
    wr(12'h020, 32'h1, 2'b10);
    rd(12'h020, rv, 2'b10);
    chk(rv, 32'h0);
    seq(16'h2005, 8'h5a, CMD_BYTE);
    wait_done;
    chk(32'(plen), 32'(4 * PER));
    chk(32'(u_flash_array_model.mem[16'h2005]), 32'h5a);
    rchk(OFF_STAT, 32'hc0);
    seq(16'h2040, 8'h11, CMD_BURST);
    seq(16'h2041, 8'h22, CMD_BURST);
    rchk(OFF_STAT, 32'h00);
    wr(OFF_ARR, 32'h00332042, 2'b00);
    rchk(OFF_STAT, 32'h10);
    wait_done;
    chk(32'(plen), 32'(8 * PER));
    chk(32'(u_flash_array_model.mem[16'h2041]), 32'h22);
    errchk(32'hd0);
    seq(16'h2123, 8'h00, CMD_PAGE);
    wait_done;
    chk(32'(elen), 32'(PE * PER));
    chk(32'(u_flash_array_model.mem[16'h2041]), 32'hff);
    wr(OFF_ARR, 32'h00003000, 2'b00);
    wr(OFF_CMD, 32'h21, 2'b00);
    errchk(32'hd0);
    wr(OFF_ARR, 32'h00003000, 2'b00);
    wr(OFF_CMD, {24'h0, CMD_BYTE}, 2'b00);
    wr(OFF_STAT, 32'h00, 2'b00);
    errchk(32'hd0);
    wr(OFF_ARR, 32'h00001040, 2'b00);
    errchk(32'hd0);
    nv_protect_setting <= 8'h00;
    seq(16'h3000, 8'h00, CMD_BYTE);
    errchk(32'he0);
    seq(16'h3000, 8'h00, CMD_MASS);
    errchk(32'he0);
    chk(32'(u_flash_array_model.mem[16'h3000]), 32'hff);
    nv_protect_setting <= 8'hc0;
    seq(16'h2000, 8'h00, CMD_MASS);
    repeat (250) @(posedge aclk);
    stop_mode_req <= 1'b1;
    repeat (10) @(posedge aclk);
    stop_mode_req <= 1'b0;
    errchk(32'hd0);
    seq(16'h3000, 8'h00, CMD_BYTE);
    wait_done;
    seq(16'h2000, 8'h00, CMD_MASS);
    wait_done;
    chk(32'(elen), 32'(ME * PER));
    seq(16'h2000, 8'h00, CMD_BLANK);
    wait_done;
    rchk(OFF_STAT, 32'hc4);
    report_and_stop;
  end
endmodule
`default_nettype wire
